// >>> core/stats_pkg.sv
// constants and types for the boot link statistics counter block
package stats_pkg;

    // clock and one-second timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SEC_NS        = 1_000_000_000;
    localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

    // widths
    localparam int SLOT_AW = 5;
    localparam int NSLOT   = 17;
    localparam int CNT_W   = 64;
    // pending sums must hold a whole scan round of maximum-length frames
    localparam int PEND_W  = 24;
    localparam int LEN_W   = 16;
    localparam int ATT_W   = 5;
    localparam int IDX_W   = 8;
    localparam int ADDR_W  = 10;
    localparam int SEC_W   = 32;
    localparam int TXMAP_W = 6;
    localparam int RXMAP_W = 2;

    // counter slots held in the counter memory
    localparam logic [SLOT_AW-1:0] SL_RX_BYTES   = 5'h00;
    localparam logic [SLOT_AW-1:0] SL_TX_BYTES   = 5'h01;
    localparam logic [SLOT_AW-1:0] SL_RX_FRAMES  = 5'h02;
    localparam logic [SLOT_AW-1:0] SL_TX_FRAMES  = 5'h03;
    localparam logic [SLOT_AW-1:0] SL_MC_BYTES   = 5'h04;
    localparam logic [SLOT_AW-1:0] SL_MC_FRAMES  = 5'h05;
    localparam logic [SLOT_AW-1:0] SL_DEFER      = 5'h06;
    localparam logic [SLOT_AW-1:0] SL_ONE_COLL   = 5'h07;
    localparam logic [SLOT_AW-1:0] SL_MULTI_COLL = 5'h08;
    localparam logic [SLOT_AW-1:0] SL_TX_FAIL    = 5'h09;
    localparam logic [SLOT_AW-1:0] SL_TX_RETRY   = 5'h0a;
    localparam logic [SLOT_AW-1:0] SL_TX_CARRIER = 5'h0b;
    localparam logic [SLOT_AW-1:0] SL_RX_FAIL    = 5'h0c;
    localparam logic [SLOT_AW-1:0] SL_RX_CRC     = 5'h0d;
    localparam logic [SLOT_AW-1:0] SL_RX_PARTIAL = 5'h0e;
    localparam logic [SLOT_AW-1:0] SL_UNCLAIMED  = 5'h0f;
    localparam logic [SLOT_AW-1:0] SL_OVERRUN    = 5'h10;
    localparam logic [SLOT_AW-1:0] SL_LAST       = 5'h10;

    // register word indices, byte address is four times the index
    localparam logic [IDX_W-1:0] NO_OFF    = 8'hff;
    localparam logic [IDX_W-1:0] TIME_IDX  = 8'h00;
    localparam logic [IDX_W-1:0] V3_MAPS   = 8'h2c;
    localparam logic [IDX_W-1:0] WORD_STEP = 8'h04;
    localparam logic [IDX_W-1:0] CTRL_IDX  = 8'hf0;
    localparam logic [IDX_W-1:0] V3_OFF [NSLOT] = '{
        8'h02, 8'h06, 8'h0a, 8'h0e, 8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22,
        8'h26, NO_OFF, NO_OFF, 8'h2a, NO_OFF, NO_OFF, 8'h2e, 8'h30};
    localparam logic [IDX_W-1:0] V4_OFF [NSLOT] = '{
        8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h50,
        NO_OFF, 8'h58, 8'h60, NO_OFF, 8'h88, 8'h90, 8'ha0, 8'ha8};
    // slots that are 4 bytes wide in the older layout, the rest are 2
    localparam logic [NSLOT-1:0] V3_WIDE = 17'h001ff;

    // saturation limits and increments
    localparam logic [CNT_W-1:0]  V3_MAX32 = 64'h0000_0000_ffff_ffff;
    localparam logic [CNT_W-1:0]  V3_MAX16 = 64'h0000_0000_0000_ffff;
    localparam logic [PEND_W-1:0] PEND_ONE = 24'h00_0001;
    localparam logic [ATT_W-1:0]  ATT_FIRST  = 5'h01;
    localparam logic [ATT_W-1:0]  ATT_SECOND = 5'h02;

    // failure map bits and control bits
    localparam int TXB_RETRY   = 0;
    localparam int TXB_CARRIER = 1;
    localparam int RXB_CRC     = 0;
    localparam int RXB_PARTIAL = 1;
    localparam int CTRL_LAYOUT = 0;
    localparam int CTRL_CLEAR  = 1;
    localparam logic CTRL_LAYOUT_RST = 1'b0;

    typedef enum logic [2:0] {
        K_ZERO, K_SLOT, K_TIME, K_MAP, K_CTRL
    } kind_t;

    typedef struct packed {
        kind_t              kind;
        logic [SLOT_AW-1:0] slot;
        logic               hi;
    } rd_sel_t;

    typedef enum logic [1:0] {
        S_SCAN_RD = 2'b00,
        S_SCAN_WR = 2'b01,
        S_BUS_RD  = 2'b11,
        S_BUS_ANS = 2'b10
    } st_t;

endpackage

// >>> core/stat_mem_if.sv
// port bundle between the statistics core and its counter memory
`timescale 1ns/1ns
`default_nettype none
interface stat_mem_if;
    import stats_pkg::*;
    logic [SLOT_AW-1:0] rd_addr;
    logic [CNT_W-1:0]   rd_data;
    logic               wr_en;
    logic [SLOT_AW-1:0] wr_addr;
    logic [CNT_W-1:0]   wr_data;
    modport ctl (output rd_addr, output wr_en, output wr_addr,
                 output wr_data, input rd_data);
    modport mem (input rd_addr, input wr_en, input wr_addr,
                 input wr_data, output rd_data);
endinterface
`default_nettype wire

// >>> core/stat_mem.sv
// counter memory with one write port and a registered read port
`timescale 1ns/1ns
`default_nettype none
module stat_mem
    import stats_pkg::*;
(
    // clock
    input  wire logic sys_clk_i,
    // access port
    stat_mem_if.mem   bus
);
    logic [CNT_W-1:0] ram [2**SLOT_AW];

    always_ff @(posedge sys_clk_i) begin
        if (bus.wr_en) begin
            ram[bus.wr_addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        bus.rd_data <= ram[bus.rd_addr];
    end
endmodule
`default_nettype wire

// >>> core/sec_tick.sv
// one-second tick generator, restarted by a counter clear
`timescale 1ns/1ns
`default_nettype none
module sec_tick
    import stats_pkg::*;
#(
    parameter int unsigned PERIOD = SEC_CYCLES
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // control and tick
    input  wire logic restart_i,
    output logic      tick_o
);
    logic [31:0] cnt_r;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || restart_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else if (cnt_r == 32'(PERIOD - 1)) begin
            cnt_r  <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> core/boot_link_stats.sv
// statistics counter block of the ethernet boot channel, avalon-mm slave
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module boot_link_stats
    import stats_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // receive events
    input  wire logic              rx_done_i,
    input  wire logic              rx_addr_match_i,
    input  wire logic              rx_multicast_i,
    input  wire logic              rx_crc_err_i,
    input  wire logic              rx_partial_err_i,
    input  wire logic [LEN_W-1:0]  rx_len_i,
    // transmit events
    input  wire logic              tx_done_i,
    input  wire logic              tx_ok_i,
    input  wire logic [LEN_W-1:0]  tx_len_i,
    input  wire logic [ATT_W-1:0]  tx_attempts_i,
    input  wire logic              tx_deferred_i,
    input  wire logic              tx_fail_retry_i,
    input  wire logic              tx_fail_carrier_i,
    // drop events
    input  wire logic              unclaimed_i,
    input  wire logic              overrun_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    stat_mem_if mem_bus ();

    st_t                state_r;
    logic [SLOT_AW-1:0] scan_r;
    logic [PEND_W-1:0]  pend_r [NSLOT];
    logic [PEND_W-1:0]  inc [NSLOT];
    logic [NSLOT-1:0]   live_r;
    logic [SEC_W-1:0]   sec_r;
    logic [TXMAP_W-1:0] tx_map_r;
    logic [RXMAP_W-1:0] rx_map_r;
    logic [TXMAP_W-1:0] tx_set;
    logic [RXMAP_W-1:0] rx_set;
    logic               layout_v4_r;
    logic               wait_r;
    logic [31:0]        rdata_r;
    logic [31:0]        rd_word;
    logic [CNT_W-1:0]   old_val;
    logic [PEND_W-1:0]  pend_cur;
    logic [IDX_W-1:0]   idx;
    rd_sel_t            sel;
    logic               tick;
    logic               rx_good;
    logic               rx_bad;
    logic               tx_good;
    logic               tx_bad;
    logic               wr_take;
    logic               clear_now;

    function automatic logic [CNT_W-1:0] cap_of(input logic wide);
        cap_of = wide ? V3_MAX32 : V3_MAX16;
    endfunction

    function automatic logic [CNT_W-1:0] bump(
        input logic [CNT_W-1:0]  old,
        input logic [PEND_W-1:0] add,
        input logic              v4,
        input logic              wide
    );
        logic [CNT_W:0] sum;
        sum = {1'b0, old} + (CNT_W+1)'(add);
        if (v4) begin
            bump = sum[CNT_W-1:0];
        end else if (sum > {1'b0, cap_of(wide)}) begin
            bump = cap_of(wide);
        end else begin
            bump = sum[CNT_W-1:0];
        end
    endfunction

    function automatic rd_sel_t decode(
        input logic             v4,
        input logic [IDX_W-1:0] i_idx
    );
        rd_sel_t s;
        s.kind = K_ZERO;
        s.slot = '0;
        s.hi   = 1'b0;
        if (i_idx == CTRL_IDX) begin
            s.kind = K_CTRL;
        end else if (i_idx == TIME_IDX) begin
            s.kind = K_TIME;
        end else if (!v4 && i_idx == V3_MAPS) begin
            s.kind = K_MAP;
        end
        for (int i = 0; i < NSLOT; i++) begin
            if (!v4 && V3_OFF[i] != NO_OFF && i_idx == V3_OFF[i]) begin
                s.kind = K_SLOT;
                s.slot = SLOT_AW'(i);
            end
            if (v4 && V4_OFF[i] != NO_OFF && (i_idx == V4_OFF[i] ||
                    i_idx == V4_OFF[i] + WORD_STEP)) begin
                s.kind = K_SLOT;
                s.slot = SLOT_AW'(i);
                s.hi   = i_idx != V4_OFF[i];
            end
        end
        return s;
    endfunction

    stat_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .bus       (mem_bus.mem)
    );

    sec_tick #(
        .PERIOD    (SEC_CYCLES_P)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .restart_i (clear_now),
        .tick_o    (tick)
    );

    // bus decode and write take
    always_comb begin
        idx       = avs_address_i[ADDR_W-1:2];
        sel       = decode(layout_v4_r, idx);
        wr_take   = avs_write_i && wait_r;
        clear_now = wr_take && idx == CTRL_IDX && avs_byteenable_i[0] &&
                    avs_writedata_i[CTRL_CLEAR];
    end

    // event classification into per-slot increments
    always_comb begin
        rx_good = rx_done_i && rx_addr_match_i &&
                  !rx_crc_err_i && !rx_partial_err_i;
        rx_bad  = rx_done_i && rx_addr_match_i &&
                  (rx_crc_err_i || rx_partial_err_i);
        tx_good = tx_done_i && tx_ok_i;
        tx_bad  = tx_done_i && !tx_ok_i;
        for (int i = 0; i < NSLOT; i++) begin
            inc[i] = '0;
        end
        if (rx_good) begin
            inc[SL_RX_BYTES] = PEND_W'(rx_len_i);
            inc[SL_RX_FRAMES] = PEND_ONE;
            if (rx_multicast_i) begin
                inc[SL_MC_BYTES] = PEND_W'(rx_len_i);
                inc[SL_MC_FRAMES] = PEND_ONE;
            end
        end
        if (tx_good) begin
            inc[SL_TX_BYTES] = PEND_W'(tx_len_i);
            inc[SL_TX_FRAMES] = PEND_ONE;
            if (tx_attempts_i == ATT_FIRST) begin
                inc[SL_DEFER] = tx_deferred_i ? PEND_ONE : '0;
            end else if (tx_attempts_i == ATT_SECOND) begin
                inc[SL_ONE_COLL] = PEND_ONE;
            end else if (tx_attempts_i > ATT_SECOND) begin
                inc[SL_MULTI_COLL] = PEND_ONE;
            end
        end
        if (tx_bad) begin
            inc[SL_TX_FAIL] = PEND_ONE;
            inc[SL_TX_RETRY]   = tx_fail_retry_i ? PEND_ONE : '0;
            inc[SL_TX_CARRIER] = tx_fail_carrier_i ? PEND_ONE : '0;
        end
        if (rx_bad) begin
            inc[SL_RX_FAIL] = PEND_ONE;
            inc[SL_RX_CRC]     = rx_crc_err_i ? PEND_ONE : '0;
            inc[SL_RX_PARTIAL] = rx_partial_err_i ? PEND_ONE : '0;
        end
        inc[SL_UNCLAIMED] = unclaimed_i ? PEND_ONE : '0;
        inc[SL_OVERRUN] = overrun_i ? PEND_ONE : '0;
        tx_set = '0;
        tx_set[TXB_RETRY]   = tx_bad && tx_fail_retry_i;
        tx_set[TXB_CARRIER] = tx_bad && tx_fail_carrier_i;
        rx_set = '0;
        rx_set[RXB_CRC]     = rx_bad && rx_crc_err_i;
        rx_set[RXB_PARTIAL] = rx_bad && rx_partial_err_i;
    end

    // pending increments; a new event wins over the drain or clear
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < NSLOT; i++) begin
            if (rst_i) begin
                pend_r[i] <= '0;
            end else if (clear_now ||
                    (state_r == S_SCAN_WR && scan_r == SLOT_AW'(i))) begin
                pend_r[i] <= inc[i];
            end else begin
                pend_r[i] <= pend_r[i] + inc[i];
            end
        end
    end

    // scan sequencer, shares the memory port with bus reads
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= S_SCAN_RD;
            scan_r  <= '0;
        end else begin
            case (state_r)
                S_SCAN_RD: begin
                    state_r <= S_SCAN_WR;
                end
                S_SCAN_WR: begin
                    scan_r  <= (scan_r == SL_LAST) ? '0 :
                               scan_r + SLOT_AW'(1);
                    state_r <= (avs_read_i && wait_r) ? S_BUS_RD :
                               S_SCAN_RD;
                end
                S_BUS_RD: begin
                    state_r <= S_BUS_ANS;
                end
                S_BUS_ANS: begin
                    state_r <= S_SCAN_RD;
                end
                default: begin
                    state_r <= S_SCAN_RD;
                end
            endcase
        end
    end

    // memory port drive and counter update
    always_comb begin
        pend_cur = pend_r[scan_r];
        old_val  = live_r[scan_r] ? mem_bus.rd_data : '0;
        mem_bus.rd_addr = (state_r == S_BUS_RD) ? sel.slot : scan_r;
        mem_bus.wr_en   = state_r == S_SCAN_WR;
        mem_bus.wr_addr = scan_r;
        mem_bus.wr_data = bump(old_val, pend_cur, layout_v4_r,
                               V3_WIDE[scan_r]);
    end

    // clear forgets every stored slot at once
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || clear_now) begin
            live_r <= '0;
        end else if (state_r == S_SCAN_WR) begin
            live_r[scan_r] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || clear_now) begin
            sec_r <= '0;
        end else if (tick) begin
            sec_r <= sec_r + SEC_W'(1);
        end
    end

    // reason maps, set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_map_r <= '0;
            rx_map_r <= '0;
        end else if (clear_now) begin
            tx_map_r <= tx_set;
            rx_map_r <= rx_set;
        end else begin
            tx_map_r <= tx_map_r | tx_set;
            rx_map_r <= rx_map_r | rx_set;
        end
    end

    // layout control register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            layout_v4_r <= CTRL_LAYOUT_RST;
        end else if (wr_take && idx == CTRL_IDX && avs_byteenable_i[0]) begin
            layout_v4_r <= avs_writedata_i[CTRL_LAYOUT];
        end
    end

    // read word assembly
    always_comb begin
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] sat;
        cnt = live_r[sel.slot] ? mem_bus.rd_data : '0;
        sat = (cnt > cap_of(V3_WIDE[sel.slot])) ?
              cap_of(V3_WIDE[sel.slot]) : cnt;
        rd_word = '0;
        case (sel.kind)
            K_SLOT: begin
                if (layout_v4_r) begin
                    // unlisted send faults fall to zero words
                    rd_word = sel.hi ? cnt[63:32] : cnt[31:0];
                end else begin
                    rd_word = sat[31:0];
                    if (sel.slot == SL_TX_FAIL) begin
                        rd_word[31:16] = 16'(tx_map_r);
                    end
                    if (sel.slot == SL_RX_FAIL) begin
                        rd_word[31:16] = 16'(rx_map_r);
                    end
                end
            end
            K_TIME: begin
                if (layout_v4_r) begin
                    rd_word = sec_r;
                end else begin
                    rd_word = (sec_r > SEC_W'(V3_MAX16)) ?
                              32'(V3_MAX16) : sec_r;
                end
            end
            K_MAP: begin
                rd_word = {16'(rx_map_r), 16'(tx_map_r)};
            end
            K_CTRL: begin
                rd_word[CTRL_LAYOUT] = layout_v4_r;
            end
            // no-buffer and other unlisted words read zero
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // avalon answer: waitrequest drops for one cycle per transfer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= 1'b1;
            if (state_r == S_BUS_ANS) begin
                wait_r  <= 1'b0;
                rdata_r <= rd_word;
            end else if (wr_take) begin
                wait_r <= 1'b0;
            end
        end
    end

    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = wait_r;

    chk_wait_single: assert property ( // bus
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_read_answer: assert property ( // bus
        state_r == S_BUS_RD |=> state_r == S_BUS_ANS ##1
        (!avs_waitrequest_o && avs_readdata_o == $past(rd_word)))
        else $error("bus read not answered two cycles after lookup");
    chk_wrap_newer: assert property (
        state_r == S_SCAN_WR && layout_v4_r |->
        mem_bus.wr_data == old_val + CNT_W'(pend_cur))
        else $error("newer layout counter did not add with wrap");
    chk_sat_older: assert property (
        state_r == S_SCAN_WR && !layout_v4_r &&
        old_val >= cap_of(V3_WIDE[scan_r]) |->
        mem_bus.wr_data == cap_of(V3_WIDE[scan_r]))
        else $error("older layout counter left its ceiling");
    chk_err_excluded: assert property (
        rx_done_i && (rx_crc_err_i || rx_partial_err_i) |->
        inc[SL_RX_FRAMES] == '0 && inc[SL_RX_BYTES] == '0)
        else $error("errored frame counted as received");
    chk_tx_class: assert property (
        $onehot0({inc[SL_DEFER] != '0, inc[SL_ONE_COLL] != '0,
                  inc[SL_MULTI_COLL] != '0}))
        else $error("frame counted in two contention classes");
    chk_map_sticky: assert property (
        tx_bad && tx_fail_retry_i |=> tx_map_r[TXB_RETRY] ##1
        (tx_map_r[TXB_RETRY] || $past(clear_now)))
        else $error("send fault reason bit not held");
    chk_clear_all: assert property (
        clear_now |=> sec_r == '0 && live_r == '0)
        else $error("clear left elapsed time or counters");
    chk_sec_step: assert property (
        tick && !clear_now |=> sec_r == $past(sec_r) + SEC_W'(1))
        else $error("elapsed time did not step on tick");

    cov_read_newer: cover property (
        state_r == S_BUS_ANS && layout_v4_r);
    cov_clear: cover property (clear_now);
    cov_tx_fault: cover property (tx_bad && tx_fail_retry_i);
    cov_saturated: cover property (
        state_r == S_SCAN_WR && !layout_v4_r &&
        old_val == cap_of(V3_WIDE[scan_r]));
endmodule
`default_nettype wire

// >>> testbench/console_model.sv
// remote console model: avalon-mm master doing one access per start
`timescale 1ns/1ns
`default_nettype none
module console_model (
    // bench side
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic        wr_i,
    input  wire logic [9:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    output logic             done_o = 1'b0,
    output logic [31:0]      rdata_o = 32'h0,
    // avalon-mm master side
    input  wire logic        wait_i,
    input  wire logic [31:0] rdata_i,
    output logic             read_o = 1'b0,
    output logic             write_o = 1'b0,
    output logic [9:0]       address_o = 10'h0,
    output logic [31:0]      writedata_o = 32'h0
);
    // request held until the edge that sees waitrequest low
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if ((read_o || write_o) && !wait_i) begin
            read_o <= 1'b0;
            write_o <= 1'b0;
            address_o <= ~address_o;
            writedata_o <= ~writedata_o;
            rdata_o <= rdata_i;
            done_o <= 1'b1;
        end else if (start_i && !read_o && !write_o) begin
            read_o <= !wr_i;
            write_o <= wr_i;
            address_o <= addr_i;
            writedata_o <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the boot link statistics counters
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import stats_pkg::*;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, wr = 1'b0;
    logic done, rd, wt, wq;
    logic [9:0] a = '0, ma;
    logic [31:0] wd = '0, mwd, rdv, rq, v, r = 32'h8953;
    logic rxd = 0, rxm = 0, rxmc = 0, rxc = 0, rxp = 0, txd = 0, txo = 0;
    logic txdf = 0, txr = 0, txc = 0, unc = 0, ovr = 0;
    logic [15:0] rxl = '0, txl = '0, txt, rxt;
    logic [4:0] txa = 5'h01;
    logic [63:0] rxb, rxf, mcb, mcf, txb, txf, dfr, c1, cm;
    logic [63:0] fr, fc, crc, prt, un, ov;
    logic [5:0] tm;
    logic [1:0] rm;
    int bad_count = 0, checked = 0;
    initial forever #25 clk = ~clk;
    boot_link_stats #(.SEC_CYCLES_P(20)) dut (.sys_clk_i(clk), .rst_i(rst),
        .avs_address_i(ma), .avs_read_i(rd), .avs_write_i(wt),
        .avs_writedata_i(mwd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rq), .avs_waitrequest_o(wq), .rx_done_i(rxd),
        .rx_addr_match_i(rxm), .rx_multicast_i(rxmc), .rx_crc_err_i(rxc),
        .rx_partial_err_i(rxp), .rx_len_i(rxl), .tx_done_i(txd),
        .tx_ok_i(txo), .tx_len_i(txl), .tx_attempts_i(txa),
        .tx_deferred_i(txdf), .tx_fail_retry_i(txr),
        .tx_fail_carrier_i(txc), .unclaimed_i(unc), .overrun_i(ovr));
    console_model cons (.clk_i(clk), .start_i(start), .wr_i(wr),
        .addr_i(a), .wdata_i(wd), .done_o(done), .rdata_o(rdv),
        .wait_i(wq), .rdata_i(rq), .read_o(rd), .write_o(wt),
        .address_o(ma), .writedata_o(mwd));
    function automatic [31:0] xs(input [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic zero_exp();
        {rxb, rxf, mcb, mcf, txb, txf, dfr, c1, cm} = '0;
        {fr, fc, crc, prt, un, ov, txt, rxt, tm, rm} = '0;
    endtask
    task automatic chk(input [63:0] g, input [63:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input w, input [7:0] i, input [31:0] d);
        @(posedge clk);
        start <= 1'b1;
        wr <= w;
        a <= {i, 2'b00};
        wd <= d;
        @(posedge clk);
        start <= 1'b0;
        // done ends the wait for the answer, no timeout but the watchdog
        do begin
            @(negedge clk);
        end while (!done);
        v = rdv;
    endtask
    task automatic c64(input [7:0] i, input [63:0] e);
        logic [31:0] lo;
        bus(1'b0, i, 32'h0);
        lo = v;
        bus(1'b0, i + 8'h04, 32'h0);
        chk({v, lo}, e);
    endtask
    task automatic summarize();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reference model of what the counters must gather
    always @(posedge clk) begin
        if (rxd && rxm && !rxc && !rxp) begin
            rxb += rxl;
            rxf++;
            if (rxmc) begin
                mcb += rxl;
                mcf++;
            end
        end
        if (rxd && rxm && (rxc || rxp)) begin
            rxt++;
            rm |= {rxp, rxc};
            crc += rxc;
            prt += rxp;
        end
        if (txd && txo) begin
            txb += txl;
            txf++;
            dfr += (txa == 5'h01 && txdf);
            c1 += (txa == 5'h02);
            cm += (txa >= 5'h03);
        end
        if (txd && !txo) begin
            txt++;
            tm |= {4'b0, txc, txr};
            fr += txr;
            fc += txc;
        end
        un += unc;
        ov += ovr;
    end
    initial begin
        zero_exp();
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 8'hf0, 32'h1);
        for (int k = 0; k < 400; k++) begin
            @(posedge clk);
            r = xs(r);
            {rxd, rxm, rxmc, txd, txo, txdf, unc, ovr} <= r[7:0];
            rxc <= (r[9:8] == 2'b00);
            rxp <= (r[9:8] == 2'b01);
            rxl <= {5'h0, r[20:10]};
            txl <= {5'h0, r[31:21]};
            txa <= {3'b0, r[11:10]} + 5'h01;
            txr <= r[12];
            txc <= !r[12];
        end
        @(posedge clk);
        {rxd, txd, unc, ovr} <= '0;
        repeat (40) @(posedge clk);
        c64(8'h10, rxb);
        c64(8'h18, txb);
        c64(8'h20, rxf);
        c64(8'h28, txf);
        c64(8'h30, mcb);
        c64(8'h38, mcf);
        c64(8'h40, dfr);
        c64(8'h48, c1);
        c64(8'h50, cm);
        c64(8'h58, fr);
        c64(8'h60, fc);
        c64(8'h80, 64'h0);
        c64(8'h88, crc);
        c64(8'h90, prt);
        c64(8'h98, 64'h0);
        c64(8'ha0, un);
        c64(8'ha8, ov);
        c64(8'hb0, 64'h0);
        bus(1'b1, 8'hf0, 32'h0);
        bus(1'b1, 8'h0a, 32'h5);
        bus(1'b0, 8'h0a, 32'h0);
        chk(v, rxf);
        bus(1'b0, 8'h26, 32'h0);
        chk(v, {10'h0, tm, txt});
        bus(1'b0, 8'h2a, 32'h0);
        chk(v, {14'h0, rm, rxt});
        bus(1'b0, 8'h32, 32'h0);
        chk(v, 64'h0);
        bus(1'b0, 8'h2c, 32'h0);
        chk(v, {14'h0, rm, 10'h0, tm});
        // overrun on every cycle drives the 2-byte counter to its ceiling
        @(posedge clk);
        ovr <= 1'b1;
        repeat (65540) @(posedge clk);
        ovr <= 1'b0;
        repeat (40) @(posedge clk);
        bus(1'b0, 8'h30, 32'h0);
        chk(v, (ov > 64'hffff) ? 64'hffff : ov);
        bus(1'b1, 8'hf0, 32'h2);
        zero_exp();
        repeat (100) @(posedge clk);
        bus(1'b0, 8'h0a, 32'h0);
        chk(v, rxf);
        bus(1'b0, 8'h26, 32'h0);
        chk(v, 64'h0);
        bus(1'b0, 8'h30, 32'h0);
        chk(v, ov);
        bus(1'b0, 8'h00, 32'h0);
        chk(v >= 32'h4 && v <= 32'h7, 64'h1);
        summarize();
    end
    initial begin
        #(50 * 90000);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
